//--- verilog/dual_adc_pkg.sv
// constants shared by the dual converter output pipeline
package dual_adc_pkg;
    localparam int WORD_WIDTH = 12;
    localparam int SAMPLE_WIDTH = 14;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LATENCY_CYCLES = 6;
    localparam int SYNC_STAGES = 2;
    localparam int FRONT_STAGES = 3;
    localparam int DELAY_STAGES = LATENCY_CYCLES - FRONT_STAGES;
    localparam int SINGLE_ENDED_SHIFT = 1;
    localparam logic signed [SAMPLE_WIDTH-1:0] CODE_MIN = -14'sd2048;
    localparam logic signed [SAMPLE_WIDTH-1:0] CODE_MAX = 14'sd2047;
    localparam logic [WORD_WIDTH-1:0] MID_OFFSET = 12'h800;
    localparam logic [WORD_WIDTH-1:0] WORD_RESET = 12'h000;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_RESET = 14'h0000;
    localparam logic FORMAT_OFFSET_BINARY = 1'b0;
    localparam logic FORMAT_TWOS_COMPLEMENT = 1'b1;
endpackage

//--- verilog/sample_delay_line.sv
// fixed-depth delay line carrying a word and its valid flag
`timescale 1ns/1ps
`default_nettype none
module sample_delay_line #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic [WIDTH-1:0] dIn,
    input wire logic vIn,
    output logic [WIDTH-1:0] dOut,
    output logic vOut
);
    import dual_adc_pkg::*;

    logic [WIDTH-1:0] data_reg [DEPTH];
    logic [WIDTH-1:0] data_next [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [DEPTH-1:0] valid_next;

    // one register stage per entry, flush drops every valid flag
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            always_comb begin
                data_next[i] = (i == 0) ? dIn : data_reg[(i == 0) ? 0 : i-1];
                valid_next[i] = flush ? 1'b0 : ((i == 0) ? vIn : valid_reg[(i == 0) ? 0 : i-1]);
            end
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    data_reg[i] <= '0;
                    valid_reg[i] <= 1'b0;
                end else begin
                    data_reg[i] <= data_next[i];
                    valid_reg[i] <= valid_next[i];
                end
            end
        end
    endgenerate

    assign dOut = data_reg[DEPTH-1];
    assign vOut = valid_reg[DEPTH-1];
endmodule
`default_nettype wire

//--- verilog/dual_adc_output_pipeline.sv
// digital output pipeline of a dual 12-bit sampling converter
// Functional notes
// - one new word per channel every clock
// - both channels captured on same rising edge
// - word appears six cycles after capture edge
// - each channel has own 12-bit bus
// - format input selects coding for both channels
// - offset binary end, quarter and mid codes
// - two's complement end, quarter and mid codes
// - single-ended double span maps to same codes
// - out-of-range input saturates at end code
// - sleep request high enters low-power state
// - format low offset binary, high two's complement
// - sleep corrupts pipeline; receiver discards until refilled
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_pipeline (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic signed [dual_adc_pkg::SAMPLE_WIDTH-1:0] sampleA,
    input wire logic signed [dual_adc_pkg::SAMPLE_WIDTH-1:0] sampleB,
    input wire logic singleEnded,
    input wire logic format_select,
    input wire logic sleep_request,
    output logic [dual_adc_pkg::WORD_WIDTH-1:0] wordA,
    output logic [dual_adc_pkg::WORD_WIDTH-1:0] wordB,
    output logic wordValid,
    output logic lowPower
);
    import dual_adc_pkg::*;

    // ----------------------------------------
    // pipeline stage map
    // ----------------------------------------
    // edge 0: both inputs land in the capture flops
    // edge 1: capture copied into the hold flops
    // edge 2: hold flops clamped into offset binary codes
    // edges 3 to 5: three plain delay stages
    // edge 6: format applied, words on both output buses
    // valid flags ride along and sleep clears them all

    // ----------------------------------------
    // control input synchronisers
    // ----------------------------------------
    logic [SYNC_STAGES-1:0] fmtSync_reg;
    logic [SYNC_STAGES-1:0] fmtSync_next;

    logic [SYNC_STAGES-1:0] sleepSync_reg;
    logic [SYNC_STAGES-1:0] sleepSync_next;

    logic [SYNC_STAGES-1:0] seSync_reg;
    logic [SYNC_STAGES-1:0] seSync_next;

    logic fmtLevel;
    logic sleepLevel;
    logic seLevel;

    // shift each pin through two flops; only the last is read
    always_comb begin
        fmtSync_next = {fmtSync_reg[SYNC_STAGES-2:0], format_select};
        sleepSync_next = {sleepSync_reg[SYNC_STAGES-2:0], sleep_request};
        seSync_next = {seSync_reg[SYNC_STAGES-2:0], singleEnded};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fmtSync_reg <= '0;
            sleepSync_reg <= '0;
            seSync_reg <= '0;
        end else begin
            fmtSync_reg <= fmtSync_next;
            sleepSync_reg <= sleepSync_next;
            seSync_reg <= seSync_next;
        end
    end

    // only the second flop of each chain feeds the logic
    assign fmtLevel = fmtSync_reg[SYNC_STAGES-1];
    assign sleepLevel = sleepSync_reg[SYNC_STAGES-1];
    assign seLevel = seSync_reg[SYNC_STAGES-1];

    // ----------------------------------------
    // sample capture and quantiser
    // ----------------------------------------
    logic signed [SAMPLE_WIDTH-1:0] capA_reg;
    logic signed [SAMPLE_WIDTH-1:0] capA_next;
    logic signed [SAMPLE_WIDTH-1:0] capB_reg;
    logic signed [SAMPLE_WIDTH-1:0] capB_next;

    logic signed [SAMPLE_WIDTH-1:0] holdA_reg;
    logic signed [SAMPLE_WIDTH-1:0] holdA_next;
    logic signed [SAMPLE_WIDTH-1:0] holdB_reg;
    logic signed [SAMPLE_WIDTH-1:0] holdB_next;

    logic [WORD_WIDTH-1:0] codeA_reg;
    logic [WORD_WIDTH-1:0] codeA_next;
    logic [WORD_WIDTH-1:0] codeB_reg;
    logic [WORD_WIDTH-1:0] codeB_next;

    logic [FRONT_STAGES-1:0] frontValid_reg;
    logic [FRONT_STAGES-1:0] frontValid_next;

    // scale and clamp a sample into an offset binary code
    function automatic logic [WORD_WIDTH-1:0] quantise(input logic signed [SAMPLE_WIDTH-1:0] s,
                                                       input logic se);
        logic signed [SAMPLE_WIDTH-1:0] scaled;
        logic signed [SAMPLE_WIDTH-1:0] clamped;
        scaled = se ? (s >>> SINGLE_ENDED_SHIFT) : s;
        if (scaled < CODE_MIN) begin
            clamped = CODE_MIN;
        end else if (scaled > CODE_MAX) begin
            clamped = CODE_MAX;
        end else begin
            clamped = scaled;
        end
        return clamped[WORD_WIDTH-1:0] ^ MID_OFFSET;
    endfunction

    // both channels taken on the same edge, then resampled, then coded
    always_comb begin
        capA_next = sampleA;
        capB_next = sampleB;
        holdA_next = capA_reg;
        holdB_next = capB_reg;
        codeA_next = quantise(holdA_reg, seLevel);
        codeB_next = quantise(holdB_reg, seLevel);
        frontValid_next = sleepLevel ? '0 : {frontValid_reg[FRONT_STAGES-2:0], 1'b1};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capA_reg <= SAMPLE_RESET;
            capB_reg <= SAMPLE_RESET;
            holdA_reg <= SAMPLE_RESET;
            holdB_reg <= SAMPLE_RESET;
            codeA_reg <= WORD_RESET;
            codeB_reg <= WORD_RESET;
            frontValid_reg <= '0;
        end else begin
            capA_reg <= capA_next;
            capB_reg <= capB_next;
            holdA_reg <= holdA_next;
            holdB_reg <= holdB_next;
            codeA_reg <= codeA_next;
            codeB_reg <= codeB_next;
            frontValid_reg <= frontValid_next;
        end
    end

    // ----------------------------------------
    // remaining pipeline delay
    // ----------------------------------------
    logic [2*WORD_WIDTH-1:0] tailData;
    logic tailValid;

    // three stages after the coder, so the output register
    // loads six edges after the capture edge
    sample_delay_line #(
        .WIDTH(2*WORD_WIDTH),
        .DEPTH(DELAY_STAGES)
    ) u_delay (
        .clk(clk),
        .rst_b(rst_b),
        .flush(sleepLevel),
        .dIn({codeA_reg, codeB_reg}),
        .vIn(frontValid_reg[FRONT_STAGES-1]),
        .dOut(tailData),
        .vOut(tailValid)
    );

    // ----------------------------------------
    // output format and power state
    // ----------------------------------------
    logic [WORD_WIDTH-1:0] wordA_reg;
    logic [WORD_WIDTH-1:0] wordA_next;
    logic [WORD_WIDTH-1:0] wordB_reg;
    logic [WORD_WIDTH-1:0] wordB_next;

    logic wordValid_reg;
    logic wordValid_next;

    logic lowPower_reg;
    logic lowPower_next;

    logic [WORD_WIDTH-1:0] fmtMask;

    // format applies to both buses; msb flip gives two's complement
    always_comb begin
        fmtMask = (fmtLevel == FORMAT_TWOS_COMPLEMENT) ? MID_OFFSET : WORD_RESET;
        wordA_next = tailData[2*WORD_WIDTH-1:WORD_WIDTH] ^ fmtMask;
        wordB_next = tailData[WORD_WIDTH-1:0] ^ fmtMask;
        wordValid_next = tailValid && !sleepLevel;
        lowPower_next = sleepLevel;
        if (sleepLevel) begin
            wordA_next = WORD_RESET;
            wordB_next = WORD_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wordA_reg <= WORD_RESET;
            wordB_reg <= WORD_RESET;
            wordValid_reg <= 1'b0;
            lowPower_reg <= 1'b0;
        end else begin
            wordA_reg <= wordA_next;
            wordB_reg <= wordB_next;
            wordValid_reg <= wordValid_next;
            lowPower_reg <= lowPower_next;
        end
    end

    // every output comes straight from its flop
    assign wordA = wordA_reg;
    assign wordB = wordB_reg;
    assign wordValid = wordValid_reg;
    assign lowPower = lowPower_reg;
endmodule
`default_nettype wire

//--- testbench/dual_adc_output_pipeline_monitor.sv
// assertion checker bound to the dual converter output pipeline
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_pipeline_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic signed [13:0] sampleA,
    input wire logic signed [13:0] sampleB,
    input wire logic singleEnded,
    input wire logic format_select,
    input wire logic sleep_request,
    input wire logic [11:0] wordA,
    input wire logic [11:0] wordB,
    input wire logic wordValid,
    input wire logic lowPower
);
    logic fmtPrev_reg;
    logic [2:0] calm_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // edges since the format pin last moved, saturating at 7
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fmtPrev_reg <= 1'b0;
            calm_reg <= 3'h0;
        end else begin
            fmtPrev_reg <= format_select;
            calm_reg <= (fmtPrev_reg != format_select) ? 3'h0 : calm_reg + {2'h0, calm_reg != 3'h7};
        end
    end
    AST_MID_A: assert property (wordValid && calm_reg == 3'h7 && $past(sampleA, 7) == 0 |->
        wordA == (format_select ? 12'h000 : 12'h800)) else $error("midscale code wrong");
    AST_TOP_A: assert property (wordValid && calm_reg == 3'h7 && $past(sampleA, 7) > 14'sd4095 |->
        wordA == (format_select ? 12'h7FF : 12'hFFF)) else $error("top saturation wrong");
    AST_BOT_B: assert property (wordValid && calm_reg == 3'h7 && $past(sampleB, 7) < -14'sd4096 |->
        wordB == (format_select ? 12'h800 : 12'h000)) else $error("bottom saturation wrong");
    AST_PAIR: assert property (wordValid && $past(sampleA, 7) == $past(sampleB, 7) |-> wordA == wordB)
        else $error("channels disagree");
    AST_SLEEP_ZERO: assert property (lowPower |-> wordA == 12'h000 && wordB == 12'h000 && !wordValid)
        else $error("words live in sleep");
    AST_SLEEP_IN: assert property ($rose(sleep_request) |-> ##[1:4] lowPower)
        else $error("sleep not entered");
    AST_WAKE: assert property ($fell(lowPower) |-> !wordValid [*6] ##1 wordValid)
        else $error("refill timing wrong");
    AST_RESET: assert property (!$past(rst_b) |-> !wordValid [*7])
        else $error("valid too early after reset");
endmodule
bind dual_adc_output_pipeline dual_adc_output_pipeline_monitor monitor_i (.clk(clk), .rst_b(rst_b),
    .sampleA(sampleA), .sampleB(sampleB), .singleEnded(singleEnded), .format_select(format_select),
    .sleep_request(sleep_request), .wordA(wordA), .wordB(wordB), .wordValid(wordValid), .lowPower(lowPower));
`default_nettype wire

//--- testbench/word_capture_model.sv
// receiving logic that captures both sample buses on the sample clock
`timescale 1ns/1ps
`default_nettype none
module word_capture_model (
    input wire logic clk,
    input wire logic [11:0] wordA,
    input wire logic [11:0] wordB,
    input wire logic wordValid,
    output logic [11:0] gotA,
    output logic [11:0] gotB,
    output logic gotValid
);
    // both buses taken on one edge; words without valid are discarded
    always_ff @(posedge clk) begin
        gotA <= wordValid ? wordA : gotA;
        gotB <= wordValid ? wordB : gotB;
        gotValid <= wordValid;
    end
endmodule
`default_nettype wire

//--- testbench/tb_dual_adc_output_pipeline.sv
// self-checking bench for the dual converter output pipeline
`timescale 1ns/1ps
`default_nettype none
module tb_dual_adc_output_pipeline;
    import dual_adc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic signed [13:0] sampleA = '0;
    logic signed [13:0] sampleB = '0;
    logic singleEnded = 1'b0;
    logic format_select = 1'b0;
    logic sleep_request = 1'b0;
    logic [11:0] wordA, wordB, gotA, gotB;
    logic wordValid, lowPower, gotValid;
    logic [11:0] histA[$], histB[$];
    int corner[9] = '{-8192, -4097, -2049, -1024, 0, 1024, 2048, 4096, 8191};
    int failures = 0;
    int comparisons = 0;
    integer seed = 35882;
    int quiet = 0;
    int cycles = 0;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    dual_adc_output_pipeline DUT (.clk(clk), .rst_b(rst_b), .sampleA(sampleA), .sampleB(sampleB),
        .singleEnded(singleEnded), .format_select(format_select), .sleep_request(sleep_request),
        .wordA(wordA), .wordB(wordB), .wordValid(wordValid), .lowPower(lowPower));
    word_capture_model partner (.clk(clk), .wordA(wordA), .wordB(wordB), .wordValid(wordValid),
        .gotA(gotA), .gotB(gotB), .gotValid(gotValid));
    // halve if single-ended, clamp, shift to offset binary, flip top bit for two's complement
    function automatic logic [11:0] expect_code(input int s, input logic se, input logic fm);
        int v;
        v = se ? s >>> 1 : s;
        v = (v > 2047) ? 2047 : (v < -2048) ? -2048 : v;
        v = v + 2048;
        return {v[11] ^ fm, v[10:0]};
    endfunction
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one sample per channel each falling edge; captured words compared eight edges later
    task automatic step(input int a, input int b);
        @(negedge clk);
        if (gotValid === 1'b1 && quiet > 12) begin
            check("wordA", histA[7], gotA);
            check("wordB", histB[7], gotB);
        end
        quiet++;
        sampleA = 14'(a);
        sampleB = 14'(b);
        histA.push_front(expect_code(a, singleEnded, format_select));
        histB.push_front(expect_code(b, singleEnded, format_select));
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        for (int m = 0; m < 4; m++) begin
            format_select = m[0];
            singleEnded = m[1];
            quiet = 0;
            for (int i = 0; i < 40; i++) begin
                if (i > 12 && i < 22) step(corner[i-13], corner[i-13]);
                else step($random(seed) % 2600, $random(seed) % 2600);
            end
            $display("test mode %0d done", m);
        end
        sleep_request = 1'b1;
        quiet = 0;
        repeat (10) step(0, 0);
        check("lowPower", 12'h001, {11'h000, lowPower});
        check("sleepWord", WORD_RESET, wordB);
        check("sleepWordA", WORD_RESET, wordA);
        sleep_request = 1'b0;
        repeat (20) step($random(seed) % 2600, 1024);
        check("wakeValid", 12'h001, {11'h000, gotValid});
        check("wakePower", 12'h000, {11'h000, lowPower});
        $display("test sleep done");
        test_done();
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            failures++;
            test_done();
        end
    end
endmodule
`default_nettype wire
